// [rtl/pucms_pkg.sv]
/*
 Shared constants and types of the power-up configuration mode selector.
 Assumes a single 10 MHz clock domain and an AXI4-Lite register master.
*/
package pucms_pkg;
  // Switch banks and operating image
  localparam int BANK_W    = 8;
  localparam int SW_W      = 3 * BANK_W;
  localparam int CFG_WORDS = 4;
  localparam int CFG_IW    = 2;
  localparam int FL_AW     = 16;
  localparam int ADDR_W    = 8;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SWITCH   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_REJECT   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CFG0     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CFG_LAST = 8'h1C;

  // Field positions and reset values
  localparam int STAT_SOFT_BIT  = 0;
  localparam int STAT_UNSUP_BIT = 1;
  localparam int STAT_DONE_BIT  = 2;
  localparam int STAT_SAVED_BIT = 3;
  localparam int CTRL_EOC_BIT   = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam logic CTRL_EOC_RST = 1'b1;

  // Flash layout
  localparam logic [FL_AW-1:0] FL_SAVED_BASE   = 16'h0000;
  localparam logic [FL_AW-1:0] FL_DEFAULT_BASE = 16'h0100;

  // Console replies and bus answers
  localparam logic [3:0] MSG_NONE        = 4'h0;
  localparam logic [3:0] MSG_SWITCH_MODE = 4'h1;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // Cycles after reset release before the switch word is trusted
  localparam logic [1:0] SYNC_WAIT = 2'h2;

  typedef enum logic [2:0] {
    ST_CAP  = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } pucms_state_t;

  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_MARK = 3'b010,
    FL_DATA = 3'b100
  } pucms_fl_state_t;
endpackage

// [rtl/pucms_sw_capture.sv]
/*
 Switch bank synchroniser and one-time capture of the switch word.
 Assumes switch pins are asynchronous; capture follows reset release.
*/
module pucms_sw_capture
  import pucms_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Switch pins, 1 = ON
  input  wire logic [SW_W-1:0]   sw_pins,
  // Captured word
  output logic      [SW_W-1:0]   sw_word_q,
  output logic                   cap_valid_q
);
  logic [SW_W-1:0] meta_q;
  logic [SW_W-1:0] sync_q;
  logic [1:0]      wait_q;
  logic [1:0]      wait_d;
  logic [SW_W-1:0] sw_word_d;
  logic            cap_valid_d;

  always_comb begin
    wait_d      = wait_q;
    sw_word_d   = sw_word_q;
    cap_valid_d = cap_valid_q;
    if (!cap_valid_q) begin
      if (wait_q == SYNC_WAIT) begin
        sw_word_d   = sync_q;
        cap_valid_d = 1'b1;
      end else begin
        wait_d = wait_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q      <= '0;
      sync_q      <= '0;
      wait_q      <= '0;
      sw_word_q   <= '0;
      cap_valid_q <= 1'b0;
    end else begin
      meta_q      <= sw_pins;
      sync_q      <= meta_q;
      wait_q      <= wait_d;
      sw_word_q   <= sw_word_d;
      cap_valid_q <= cap_valid_d;
    end
  end

  // Later switch moves never reach the captured word
  word_frozen_a: assert property (@(posedge clk) disable iff (!rst_b)
    cap_valid_q |=> cap_valid_q && $stable(sw_word_q))
    else $error("captured switch word changed while running");
endmodule

// [rtl/pucms_flash_load.sv]
/*
 Loads the operating image from flash: saved image if marked, else default.
 Assumes flash answers each held request with one ack pulse and its data.
*/
module pucms_flash_load
  import pucms_pkg::*;
#(
  parameter logic [31:0] SAVED_MARK = 32'hA5A5_0001  // Arbitrary marker value
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              start,
  // Flash read port
  output logic                   flash_req,
  output logic      [FL_AW-1:0]  flash_addr_q,
  input  wire logic [31:0]       flash_rdata,
  input  wire logic              flash_ack,
  // Image words out
  output logic                   wr_en,
  output logic      [CFG_IW-1:0] wr_idx_q,
  output logic                   done,
  output logic                   from_saved_q
);
  pucms_fl_state_t  st_q;
  pucms_fl_state_t  st_d;
  logic [FL_AW-1:0] flash_addr_d;
  logic [CFG_IW-1:0] wr_idx_d;
  logic             from_saved_d;
  logic             mark_ok;

  assign flash_req = (st_q != FL_IDLE);
  assign mark_ok   = (flash_rdata == SAVED_MARK);
  assign wr_en     = (st_q == FL_DATA) && flash_ack;
  assign done      = wr_en && (wr_idx_q == CFG_IW'(CFG_WORDS - 1));

  always_comb begin
    st_d         = st_q;
    flash_addr_d = flash_addr_q;
    wr_idx_d     = wr_idx_q;
    from_saved_d = from_saved_q;
    unique case (st_q)
      FL_IDLE: begin
        if (start) begin
          st_d         = FL_MARK;
          flash_addr_d = FL_SAVED_BASE;
        end
      end
      FL_MARK: begin
        if (flash_ack) begin
          st_d         = FL_DATA;
          wr_idx_d     = '0;
          from_saved_d = mark_ok;
          // Image words follow the marker word
          flash_addr_d = (mark_ok ? FL_SAVED_BASE : FL_DEFAULT_BASE) + FL_AW'(1);
        end
      end
      FL_DATA: begin
        if (flash_ack) begin
          flash_addr_d = flash_addr_q + FL_AW'(1);
          wr_idx_d     = wr_idx_q + CFG_IW'(1);
          if (done) begin
            st_d = FL_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q         <= FL_IDLE;
      flash_addr_q <= '0;
      wr_idx_q     <= '0;
      from_saved_q <= 1'b0;
    end else begin
      st_q         <= st_d;
      flash_addr_q <= flash_addr_d;
      wr_idx_q     <= wr_idx_d;
      from_saved_q <= from_saved_d;
    end
  end

  saved_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == FL_MARK && flash_ack && mark_ok)
      |=> from_saved_q && flash_addr_q == FL_SAVED_BASE + FL_AW'(1))
    else $error("saved image not chosen");

  default_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == FL_MARK && flash_ack && !mark_ok)
      |=> !from_saved_q && flash_addr_q == FL_DEFAULT_BASE + FL_AW'(1))
    else $error("default image not chosen");
endmodule

// [rtl/pucms_top.sv]
/*
 Power-up configuration mode selector with AXI4-Lite status registers.
 Assumes one clock, a synchronous power-on reset, flash and edit ports on clk.
*/
// Notes on behaviour
// - Rate and option banks all ON at power-up select software configuration.
// - In software configuration a saved flash image becomes the operating image.
// - With no saved image the default flash image is loaded instead.
// - After power-up, software configuration accepts console and channel edits.
// - A pattern neither all OFF nor all ON selects switch configuration.
// - Switch configuration takes the operating image from the captured switches.
// - The mode chosen at power-up holds until the next reset.
// - Switch moves while running never change the operating image.
// - Switch configuration refuses console edits.
// - A refused console edit is answered with the switch-mode reply code.
// - Switch configuration ignores edits from the operations channel.
module pucms_top
  import pucms_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Switch banks, 1 = ON
  input  wire logic [BANK_W-1:0]        rate_switch_bank,
  input  wire logic [BANK_W-1:0]        option_switch_bank,
  input  wire logic [BANK_W-1:0]        mgmt_address_switch_bank,
  // Flash read port
  output logic                          flash_req,
  output logic      [FL_AW-1:0]         flash_addr,
  input  wire logic [31:0]              flash_rdata,
  input  wire logic                     flash_ack,
  // Console edit port
  input  wire logic                     con_req,
  input  wire logic [CFG_IW-1:0]        con_idx,
  input  wire logic [31:0]              con_data,
  output logic                          con_ready,
  output logic                          con_ack_q,
  output logic                          con_refused_q,
  output logic      [3:0]               con_reply_q,
  // Operations channel edit port
  input  wire logic                     eoc_req,
  input  wire logic [CFG_IW-1:0]        eoc_idx,
  input  wire logic [31:0]              eoc_data,
  output logic                          eoc_ready,
  output logic                          eoc_ack_q,
  output logic                          eoc_ignored_q,
  // Operating image and mode
  output logic      [CFG_WORDS*32-1:0]  op_cfg,
  output logic                          soft_mode_q,
  output logic                          cfg_ready,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]        awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic      [1:0]               bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [ADDR_W-1:0]        araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic      [31:0]              rdata,
  output logic      [1:0]               rresp,
  output logic                          rvalid,
  input  wire logic                     rready
);
  logic [SW_W-1:0]   sw_word;
  logic              sw_valid;
  logic              ld_start;
  logic              ld_wr;
  logic [CFG_IW-1:0] ld_idx;
  logic              ld_done;
  logic              ld_saved;
  logic              all_on;
  logic              all_off;

  pucms_sw_capture u_cap (
    .clk         (clk),
    .rst_b       (rst_b),
    .sw_pins     ({mgmt_address_switch_bank, option_switch_bank, rate_switch_bank}),
    .sw_word_q   (sw_word),
    .cap_valid_q (sw_valid)
  );

  pucms_flash_load u_load (
    .clk          (clk),
    .rst_b        (rst_b),
    .start        (ld_start),
    .flash_req    (flash_req),
    .flash_addr_q (flash_addr),
    .flash_rdata  (flash_rdata),
    .flash_ack    (flash_ack),
    .wr_en        (ld_wr),
    .wr_idx_q     (ld_idx),
    .done         (ld_done),
    .from_saved_q (ld_saved)
  );

  // Mode decision uses rate and option banks only
  assign all_on  = &sw_word[2*BANK_W-1:0];
  assign all_off = ~|sw_word[2*BANK_W-1:0];

  // Mode and image state
  pucms_state_t state_q;
  pucms_state_t state_d;
  logic [31:0]  cfg_q [CFG_WORDS];
  logic [31:0]  cfg_d [CFG_WORDS];
  logic         soft_mode_d;
  logic         unsup_q;
  logic         unsup_d;
  logic         saved_q;
  logic         saved_d;
  logic         con_take;
  logic         eoc_take;
  logic         eoc_en_q;

  assign cfg_ready = (state_q == ST_RUN);
  assign con_ready = cfg_ready;
  assign eoc_ready = cfg_ready;
  assign con_take  = con_req && con_ready;
  assign eoc_take  = eoc_req && eoc_ready;
  assign ld_start  = (state_q == ST_CAP) && sw_valid && (all_on || all_off);

  always_comb begin
    state_d     = state_q;
    soft_mode_d = soft_mode_q;
    unsup_d     = unsup_q;
    saved_d     = saved_q;
    cfg_d       = cfg_q;
    unique case (state_q)
      ST_CAP: begin
        if (sw_valid) begin
          soft_mode_d = all_on || all_off;
          unsup_d     = all_off;
          if (all_on || all_off) begin
            state_d = ST_LOAD;
          end else begin
            cfg_d[0] = {{(32-SW_W){1'b0}}, sw_word};
            state_d  = ST_RUN;
          end
        end
      end
      ST_LOAD: begin
        if (ld_wr) begin
          cfg_d[ld_idx] = flash_rdata;
        end
        if (ld_done) begin
          saved_d = ld_saved;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Mode never revisited; console edit wins a same-word clash
        if (eoc_take && soft_mode_q && eoc_en_q) begin
          cfg_d[eoc_idx] = eoc_data;
        end
        if (con_take && soft_mode_q) begin
          cfg_d[con_idx] = con_data;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q     <= ST_CAP;
      soft_mode_q <= 1'b0;
      unsup_q     <= 1'b0;
      saved_q     <= 1'b0;
      cfg_q       <= '{default: '0};
    end else begin
      state_q     <= state_d;
      soft_mode_q <= soft_mode_d;
      unsup_q     <= unsup_d;
      saved_q     <= saved_d;
      cfg_q       <= cfg_d;
    end
  end

  for (genvar gi = 0; gi < CFG_WORDS; gi++) begin : g_out
    assign op_cfg[gi*32 +: 32] = cfg_q[gi];
  end

  // Edit replies and reject counter
  logic        con_ack_d;
  logic        con_refused_d;
  logic [3:0]  con_reply_d;
  logic        eoc_ack_d;
  logic        eoc_ignored_d;
  logic [31:0] reject_q;
  logic [31:0] reject_d;
  logic        eoc_en_d;
  logic        rej_clr;

  always_comb begin
    con_ack_d     = con_take && soft_mode_q;
    con_refused_d = con_take && !soft_mode_q;
    con_reply_d   = con_reply_q;
    if (con_take) begin
      con_reply_d = soft_mode_q ? MSG_NONE : MSG_SWITCH_MODE;
    end
    eoc_ack_d     = eoc_take && soft_mode_q && eoc_en_q;
    eoc_ignored_d = eoc_take && !(soft_mode_q && eoc_en_q);
    reject_d      = rej_clr ? '0 : reject_q;
    // Counting wins over a same-cycle clear
    if (con_refused_d || eoc_ignored_d) begin
      reject_d = reject_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      con_ack_q     <= 1'b0;
      con_refused_q <= 1'b0;
      con_reply_q   <= MSG_NONE;
      eoc_ack_q     <= 1'b0;
      eoc_ignored_q <= 1'b0;
      reject_q      <= '0;
    end else begin
      con_ack_q     <= con_ack_d;
      con_refused_q <= con_refused_d;
      con_reply_q   <= con_reply_d;
      eoc_ack_q     <= eoc_ack_d;
      eoc_ignored_q <= eoc_ignored_d;
      reject_q      <= reject_d;
    end
  end

  // AXI4-Lite slave
  logic              aw_hold_q, aw_hold_d;
  logic              w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0]       w_data_q, w_data_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              do_wr;
  logic              ar_take;

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready  = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q;
  assign ar_take = arvalid && arready;
  assign rej_clr = do_wr && aw_addr_q == REG_CTRL && w_strb_q[0] && w_data_q[CTRL_CLR_BIT];

  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q && !bready;
    bresp_d   = bresp_q;
    eoc_en_d  = eoc_en_q;
    if (awvalid && awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      if (aw_addr_q == REG_CTRL) begin
        if (w_strb_q[0]) begin
          eoc_en_d = w_data_q[CTRL_EOC_BIT];
        end
      end else if (!(aw_addr_q == REG_STATUS || aw_addr_q == REG_SWITCH
                     || aw_addr_q == REG_REJECT
                     || (aw_addr_q >= REG_CFG0 && aw_addr_q <= REG_CFG_LAST))) begin
        bresp_d = RESP_SLVERR;
      end
    end
    rvalid_d = rvalid_q && !rready;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      if (araddr == REG_STATUS) begin
        rdata_d[STAT_SOFT_BIT]  = soft_mode_q;
        rdata_d[STAT_UNSUP_BIT] = unsup_q;
        rdata_d[STAT_DONE_BIT]  = cfg_ready;
        rdata_d[STAT_SAVED_BIT] = saved_q;
      end else if (araddr == REG_SWITCH) begin
        rdata_d[SW_W-1:0] = sw_word;
      end else if (araddr == REG_CTRL) begin
        rdata_d[CTRL_EOC_BIT] = eoc_en_q;
      end else if (araddr == REG_REJECT) begin
        rdata_d = reject_q;
      end else if (araddr >= REG_CFG0 && araddr <= REG_CFG_LAST) begin
        rdata_d = cfg_q[araddr[CFG_IW+1:2]];
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      eoc_en_q  <= CTRL_EOC_RST;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      eoc_en_q  <= eoc_en_d;
    end
  end

  // Checks
  soft_mode_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_CAP && sw_valid && all_on) |=> soft_mode_q && state_q == ST_LOAD)
    else $error("all-ON pattern did not select software mode");

  switch_mode_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_CAP && sw_valid && !all_on && !all_off)
      |=> !soft_mode_q && state_q == ST_RUN)
    else $error("mixed pattern did not select switch mode");

  all_off_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_CAP && sw_valid && all_off) |=> soft_mode_q && unsup_q)
    else $error("all-OFF pattern not flagged");

  mode_locked_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_ready |=> cfg_ready && $stable(soft_mode_q))
    else $error("mode changed while running");

  switch_image_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_ready && !soft_mode_q) |-> cfg_q[0] == {{(32-SW_W){1'b0}}, sw_word})
    else $error("switch image differs from captured switches");

  edit_accept_a: assert property (@(posedge clk) disable iff (!rst_b)
    (con_take && soft_mode_q) |=> con_ack_q && cfg_q[$past(con_idx)] == $past(con_data))
    else $error("console edit not applied");

  console_block_a: assert property (@(posedge clk) disable iff (!rst_b)
    (con_take && !soft_mode_q) |=> $stable(op_cfg) && !con_ack_q)
    else $error("console edit applied in switch mode");

  console_reply_a: assert property (@(posedge clk) disable iff (!rst_b)
    (con_take && !soft_mode_q) |=> con_refused_q && con_reply_q == MSG_SWITCH_MODE)
    else $error("refused console edit lacks reply");

  channel_block_a: assert property (@(posedge clk) disable iff (!rst_b)
    (eoc_take && !soft_mode_q) |=> eoc_ignored_q && !eoc_ack_q && $stable(op_cfg))
    else $error("channel edit applied in switch mode");
endmodule

// [bench/pucms_flash_model.sv]
/*
 Flash memory model for the image loader.
 Assumes each request is held until its ack.
*/
module pucms_flash_model #(
  parameter logic [31:0] MARK = 32'hA5A5_0001  // Arbitrary marker value
) (
  // Clock and image choice
  input  wire logic        clk,
  input  wire logic        saved,
  // Read port
  input  wire logic        flash_req,
  input  wire logic [15:0] flash_addr,
  output logic      [31:0] flash_rdata,
  output logic             flash_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q = 2'h0;
  logic       slow_q = 1'b0;
  initial flash_ack = 1'b0;
  initial flash_rdata = 32'h0;
  // Prompt and slow answers alternate; idle data toggles
  always @(posedge clk) begin
    flash_ack <= 1'b0;
    flash_rdata <= ~flash_rdata;
    if (flash_req && !flash_ack && wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else if (flash_req && !flash_ack) begin
      flash_ack <= 1'b1;
      flash_rdata <= (flash_addr == 16'h0 && saved) ? MARK : {flash_addr, ~flash_addr};
      wait_q <= slow_q ? 2'h2 : 2'h0;
      slow_q <= !slow_q;
    end
  end
endmodule

// [bench/testbench.sv]
/*
 Self-checking bench for the configuration mode selector.
 Assumes the flash model beside the design; registers over AXI4-Lite.
*/
module testbench
  import pucms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0, rst_b = 1'b0, saved = 1'b0;
  logic [7:0]        rate = '0, opt = '0, mgmt = '0, awaddr = '0, araddr = '0;
  logic              con_req = 1'b0, eoc_req = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic              bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]        con_idx = '0, eoc_idx = '0, bresp, rresp;
  logic [31:0]       con_data = '0, eoc_data = '0, wdata = '0, rdata, flash_rdata;
  logic [15:0]       flash_addr;
  logic [3:0]        con_reply_q;
  logic [127:0]      op_cfg, exp_cfg;
  logic              flash_req, flash_ack, con_ready, con_ack_q, con_refused_q, eoc_ready;
  logic              eoc_ack_q, eoc_ignored_q, soft_mode_q, cfg_ready;
  logic              awready, wready, bvalid, arready, rvalid;
  int                mismatches = 0, cmp_count = 0;

  always #50 clk = ~clk;

  pucms_top dut_u (.clk, .rst_b, .rate_switch_bank(rate), .option_switch_bank(opt),
    .mgmt_address_switch_bank(mgmt), .flash_req, .flash_addr, .flash_rdata, .flash_ack,
    .con_req, .con_idx, .con_data, .con_ready, .con_ack_q, .con_refused_q, .con_reply_q,
    .eoc_req, .eoc_idx, .eoc_data, .eoc_ready, .eoc_ack_q, .eoc_ignored_q, .op_cfg,
    .soft_mode_q, .cfg_ready, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);
  pucms_flash_model flash_u (.clk, .saved, .flash_req, .flash_addr, .flash_rdata, .flash_ack);

  task automatic chk(input logic [131:0] g, input logic [131:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Power-up with given switches; expects the flash image
  task automatic boot(input logic [7:0] r, o, m, input logic s);
    logic [15:0] a;
    @(posedge clk);
    rst_b <= 1'b0;
    rate <= r;
    opt <= o;
    mgmt <= m;
    saved <= s;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int n = 0; n < 80 && cfg_ready !== 1'b1; n++) @(negedge clk);
    chk({cfg_ready, con_ready, eoc_ready, flash_req}, 4'hE, "image ready");
    for (int k = 0; k < 4; k++) begin
      a = (s ? FL_SAVED_BASE : FL_DEFAULT_BASE) + 16'(k + 1);
      exp_cfg[32*k +: 32] = {a, ~a};
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({tb, r}, {1'b1, er}, "write response");
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [33:0] got;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      got = {rresp, rdata};
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({tr, got}, {1'b1, er, ed}, "read");
  endtask

  // One edit on console (ch=0) or channel (ch=1)
  task automatic edit(input bit ch, input logic [1:0] i, input logic [31:0] d, input bit ok);
    @(posedge clk);
    if (ch) begin
      eoc_req <= 1'b1;
      eoc_idx <= i;
      eoc_data <= d;
    end else begin
      con_req <= 1'b1;
      con_idx <= i;
      con_data <= d;
    end
    @(posedge clk);
    con_req <= 1'b0;
    eoc_req <= 1'b0;
    @(negedge clk);
    if (ok) exp_cfg[32*i +: 32] = d;
    chk(ch ? eoc_ack_q : con_ack_q, ok, "edit applied");
    chk(ch ? eoc_ignored_q : con_refused_q, !ok, "edit refused");
    chk(op_cfg, exp_cfg, "image after edit");
  endtask

  initial begin
    #1000000;
    mismatches++;
    end_sim;
  end

  initial begin
    boot(8'hFF, 8'hFF, 8'h3C, 1'b1);
    chk({soft_mode_q, op_cfg}, {1'b1, exp_cfg}, "saved image");
    axi_rd(REG_STATUS, 32'h0000_000D, RESP_OKAY);
    axi_rd(REG_SWITCH, 32'h003C_FFFF, RESP_OKAY);
    edit(1'b0, 2'h2, 32'hCAFE_0001, 1'b1);
    edit(1'b1, 2'h3, 32'hBEEF_0002, 1'b1);
    axi_rd(REG_CFG_LAST, exp_cfg[127:96], RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    edit(1'b1, 2'h1, 32'hDEAD_0003, 1'b0);
    axi_rd(REG_REJECT, 32'h0000_0001, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
    axi_rd(REG_REJECT, 32'h0000_0000, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    $display("test soft saved done");
    boot(8'hFF, 8'hFF, 8'h01, 1'b0);
    chk({soft_mode_q, op_cfg}, {1'b1, exp_cfg}, "default image");
    axi_rd(REG_STATUS, 32'h0000_0005, RESP_OKAY);
    $display("test soft default done");
    boot(8'hFF, 8'h7F, 8'h12, 1'b1);
    exp_cfg = {96'h0, 8'h00, 8'h12, 8'h7F, 8'hFF};
    chk({soft_mode_q, op_cfg}, {1'b0, exp_cfg}, "switch image");
    @(posedge clk);
    opt <= 8'hFF;
    mgmt <= 8'h00;
    repeat (10) @(negedge clk);
    chk({soft_mode_q, op_cfg}, {1'b0, exp_cfg}, "switch moved");
    axi_rd(REG_SWITCH, 32'h0012_7FFF, RESP_OKAY);
    edit(1'b0, 2'h0, 32'h1111_1111, 1'b0);
    chk(con_reply_q, MSG_SWITCH_MODE, "reply");
    edit(1'b1, 2'h1, 32'h2222_2222, 1'b0);
    axi_rd(REG_REJECT, 32'h0000_0002, RESP_OKAY);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    $display("test switch mode done");
    boot(8'h00, 8'h00, 8'h07, 1'b0);
    chk({soft_mode_q, op_cfg}, {1'b1, exp_cfg}, "all off");
    axi_rd(REG_STATUS, 32'h0000_0007, RESP_OKAY);
    $display("test all off done");
    end_sim;
  end
endmodule
